// *** design/dfs_blink.sv ***
// Purpose: Bicolour LED pattern generator
// Assumes: tick is a one-cycle pulse every millisecond
// Notes: Pattern restarts whenever the requested mode changes
`default_nettype none
module dfs_blink (
   input wire logic clk_sys,
   input wire logic nrst,
   dfs_pat_if.gen p
);
   logic [10:0] cnt;
   logic [10:0] next_cnt;
   logic [10:0] limit;
   logic [2:0] idx;
   logic [2:0] next_idx;
   dfs_pkg::dfs_phase_t ph;
   dfs_pkg::dfs_phase_t next_ph;
   dfs_pkg::dfs_pat_t mode_q;
   logic [2:0] count_q;
   logic green_q;
   logic red_q;
   logic next_green;
   logic next_red;
   logic code;
   logic on;

   always_comb begin
      next_cnt = cnt;
      next_ph = ph;
      next_idx = idx;
      code = (p.mode == dfs_pkg::PAT_CODE);
      if (code) begin
         if (ph == dfs_pkg::PH_ON) begin
            limit = dfs_pkg::RED_ON_MS;
         end else if (ph == dfs_pkg::PH_OFF) begin
            limit = dfs_pkg::RED_OFF_MS;
         end else begin
            limit = dfs_pkg::RED_PAUSE_MS;
         end
      end else if (p.mode == dfs_pkg::PAT_FAST) begin
         limit = dfs_pkg::FAST_HALF_MS;
      end else begin
         limit = dfs_pkg::SLOW_HALF_MS;
      end
      // A new fault code in flash mode restarts the group
      if (p.mode != mode_q || p.count != count_q) begin
         next_cnt = 11'h000;
         next_ph = dfs_pkg::PH_ON;
         next_idx = 3'h1;
      end else if (p.tick) begin
         if (cnt + 11'h001 >= limit) begin
            next_cnt = 11'h000;
            case (ph)
               dfs_pkg::PH_ON: begin
                  if (code && idx == p.count) begin
                     next_ph = dfs_pkg::PH_PAUSE;
                  end else begin
                     next_ph = dfs_pkg::PH_OFF;
                  end
               end
               dfs_pkg::PH_OFF: begin
                  next_ph = dfs_pkg::PH_ON;
                  if (code) begin
                     next_idx = idx + 3'h1;
                  end
               end
               default: begin
                  next_ph = dfs_pkg::PH_ON;
                  next_idx = 3'h1;
               end
            endcase
         end else begin
            next_cnt = cnt + 11'h001;
         end
      end
      on = (next_ph == dfs_pkg::PH_ON);
      next_green = (p.mode == dfs_pkg::PAT_GREEN)
         || ((p.mode == dfs_pkg::PAT_SLOW || p.mode == dfs_pkg::PAT_FAST) && on);
      next_red = (p.mode == dfs_pkg::PAT_RED) || (code && on);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt <= 11'h000;
         ph <= dfs_pkg::PH_ON;
         idx <= 3'h1;
         mode_q <= dfs_pkg::PAT_RED;
         count_q <= 3'h0;
         green_q <= 1'b0;
         red_q <= 1'b1;
      end else begin
         cnt <= next_cnt;
         ph <= next_ph;
         idx <= next_idx;
         mode_q <= p.mode;
         count_q <= p.count;
         green_q <= next_green;
         red_q <= next_red;
      end
   end

   assign p.green = green_q;
   assign p.red = red_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_steady_green: assert property (p.mode == dfs_pkg::PAT_GREEN |=> p.green && !p.red)
      else $error("Steady green not shown");
   a_steady_red: assert property (p.mode == dfs_pkg::PAT_RED |=> p.red && !p.green)
      else $error("Steady red not shown");
   a_code_count: assert property (code && ph == dfs_pkg::PH_ON && p.count == count_q
      |-> idx <= p.count)
      else $error("Flash index beyond fault code");
   a_pause_dark: assert property (code && $stable(p.mode) && ph == dfs_pkg::PH_PAUSE
      && next_ph == dfs_pkg::PH_PAUSE |=> !p.red)
      else $error("Red lit during pause");
   a_blink_rate: assert property (p.mode == dfs_pkg::PAT_FAST && $stable(p.mode)
      && p.tick && ph == dfs_pkg::PH_ON && cnt == dfs_pkg::FAST_HALF_MS - 11'h001
      |=> ph == dfs_pkg::PH_OFF)
      else $error("Fast green half period wrong");
   c_code_pause: cover property (code && ph == dfs_pkg::PH_PAUSE && p.count == 3'h5);
   c_slow_toggle: cover property (p.mode == dfs_pkg::PAT_SLOW && $fell(p.green));
endmodule
`default_nettype wire

// *** design/dfs_pat_if.sv ***
// Purpose: Carries the LED pattern request and the LED drive
// Assumes: Single clock domain
// Notes: ctl side picks the pattern, gen side blinks it
`default_nettype none
interface dfs_pat_if;
   dfs_pkg::dfs_pat_t mode;
   logic [2:0] count;
   logic tick;
   logic green;
   logic red;
   modport ctl (output mode, output count, output tick, input green, input red);
   modport gen (input mode, input count, input tick, output green, output red);
endinterface
`default_nettype wire

// *** design/dfs_pkg.sv ***
// Purpose: Shared constants and types for the drive fault status indicator
// Assumes: 50 MHz system clock, 1 ms time base
// Notes: All blink timing is counted in milliseconds
`default_nettype none
package dfs_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int MS_W = 11;
   localparam logic [10:0] POWERUP_MS = 11'h1f4;
   localparam logic [10:0] SLOW_HALF_MS = 11'h1f4;
   localparam logic [10:0] FAST_HALF_MS = 11'h064;
   localparam logic [10:0] RED_ON_MS = 11'h0fa;
   localparam logic [10:0] RED_OFF_MS = 11'h0fa;
   localparam logic [10:0] RED_PAUSE_MS = 11'h5dc;
   localparam logic [2:0] FC_NONE = 3'h0;
   localparam logic [2:0] FC_STALL = 3'h1;
   localparam logic [2:0] FC_UNDERVOLT = 3'h2;
   localparam logic [2:0] FC_OVERVOLT = 3'h3;
   localparam logic [2:0] FC_OVERCURRENT = 3'h4;
   localparam logic [2:0] FC_INTERLOCK = 3'h5;
   localparam logic [2:0] FC_OVERTEMP = 3'h6;
   localparam logic [2:0] FC_NVM_CHECKSUM = 3'h7;
   localparam logic [2:0] SYNC_RESET = 3'h2;

   typedef enum logic [4:0] {
      PAT_GREEN = 5'h01,
      PAT_SLOW = 5'h02,
      PAT_FAST = 5'h04,
      PAT_RED = 5'h08,
      PAT_CODE = 5'h10
   } dfs_pat_t;

   typedef enum logic [2:0] {
      PH_ON = 3'h1,
      PH_OFF = 3'h2,
      PH_PAUSE = 3'h4
   } dfs_phase_t;

   typedef enum logic [2:0] {
      ST_PWRUP = 3'h1,
      ST_NOPROBE = 3'h2,
      ST_RUN = 3'h4
   } dfs_state_t;
endpackage
`default_nettype wire

// *** design/dfs_top.sv ***
// Purpose: Drive fault supervision, amplifier enable and status LED
// Assumes: Fault event and probe inputs come from logic on clk_sys
// Notes: Pins are filtered by a three-stage synchroniser
`default_nettype none
// Overview of operation
// - Steady green when running normally with no fault and amplifier enabled.
// - Slow green flashing while shut down with no fault.
// - Rapid green flashing while a regeneration dump runs.
// - Faults show red; after power-up, steady red only means motor not yet probed.
// - Latched faults flash red one to seven times by class.
// - Power cycle, serial reset or reset logic input clears a latched fault.
// - Completed motor probe leaves the steady red state.
// - Brief red at power-up, then green if no fault.
// - Active shutdown input disables the amplifier and motor.
// - Inactive shutdown input keeps amplifier enabled and motor energised.
// - Shutdown input polarity is selectable.
// - Fault output goes high whenever a red condition other than the power-up red is present.
// - Fault output stays on while a fault code keeps flashing.
// - Open safety loop cuts current, latches fault, shows five flashes.
module dfs_top #(
   parameter int TICK_CYCLES = dfs_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic amplifier_disable_input,
   input wire logic motor_safety_loop,
   input wire logic reset_input,
   input wire logic sd_active_high,
   input wire logic reset_cmd,
   input wire logic motor_probed,
   input wire logic regen_dump,
   input wire logic fault_stall,
   input wire logic fault_undervolt,
   input wire logic fault_overvolt,
   input wire logic fault_overcurrent,
   input wire logic fault_overtemp,
   input wire logic fault_nvm_checksum,
   output logic led_green,
   output logic led_red,
   output logic fault_out,
   output logic amp_enable
);
   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

   logic [2:0] pin_in;
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] filt;
   logic [2:0] next_filt;
   logic rst_in_q;
   logic [15:0] tick_cnt;
   logic [15:0] next_tick_cnt;
   logic tick;
   logic [10:0] pu_cnt;
   logic [10:0] next_pu_cnt;
   dfs_pkg::dfs_state_t state;
   dfs_pkg::dfs_state_t next_state;
   logic [2:0] fault_code;
   logic [2:0] next_code;
   logic [2:0] evt_code;
   logic [7:1] evt;
   logic shutdown;
   logic loop_ok;
   logic clear_req;
   logic next_amp;
   logic next_fault_out;
   dfs_pkg::dfs_pat_t pat;

   dfs_pat_if pif ();

   // Pin synchroniser, change accepted when stages two and three agree
   assign pin_in = {reset_input, motor_safety_loop, amplifier_disable_input};
   for (genvar i = 0; i < 3; i++) begin : g_sync
      assign next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s1 <= dfs_pkg::SYNC_RESET;
         s2 <= dfs_pkg::SYNC_RESET;
         s3 <= dfs_pkg::SYNC_RESET;
         filt <= dfs_pkg::SYNC_RESET;
         rst_in_q <= 1'b0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
         rst_in_q <= filt[2];
      end
   end

   // Millisecond tick divider
   always_comb begin
      tick = (tick_cnt == TICK_LAST);
      next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // Supervision and fault latch
   always_comb begin
      shutdown = sd_active_high ? filt[0] : !filt[0];
      loop_ok = filt[1];
      clear_req = reset_cmd || (filt[2] && !rst_in_q);
      evt = {fault_nvm_checksum, fault_overtemp, !loop_ok, fault_overcurrent,
             fault_overvolt, fault_undervolt, fault_stall};
      evt_code = dfs_pkg::FC_NONE;
      for (int k = 7; k >= 1; k--) begin
         if (evt[k]) begin
            evt_code = 3'(k);
         end
      end
      next_code = fault_code;
      if (clear_req) begin
         next_code = evt_code;
      end else if (fault_code == dfs_pkg::FC_NONE) begin
         next_code = evt_code;
      end
      next_state = state;
      next_pu_cnt = pu_cnt;
      case (state)
         dfs_pkg::ST_PWRUP: begin
            if (tick) begin
               next_pu_cnt = pu_cnt + 11'h001;
               if (pu_cnt + 11'h001 >= dfs_pkg::POWERUP_MS) begin
                  next_state = motor_probed ? dfs_pkg::ST_RUN : dfs_pkg::ST_NOPROBE;
               end
            end
         end
         dfs_pkg::ST_NOPROBE: begin
            if (motor_probed) begin
               next_state = dfs_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = dfs_pkg::ST_RUN;
         end
      endcase
      next_amp = (state == dfs_pkg::ST_RUN) && (next_code == dfs_pkg::FC_NONE)
         && !shutdown && loop_ok;
      next_fault_out = (next_code != dfs_pkg::FC_NONE)
         || (next_state == dfs_pkg::ST_NOPROBE);
      if (state == dfs_pkg::ST_PWRUP) begin
         pat = dfs_pkg::PAT_RED;
      end else if (fault_code != dfs_pkg::FC_NONE) begin
         pat = dfs_pkg::PAT_CODE;
      end else if (state == dfs_pkg::ST_NOPROBE) begin
         pat = dfs_pkg::PAT_RED;
      end else if (regen_dump) begin
         pat = dfs_pkg::PAT_FAST;
      end else if (shutdown) begin
         pat = dfs_pkg::PAT_SLOW;
      end else begin
         pat = dfs_pkg::PAT_GREEN;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= dfs_pkg::ST_PWRUP;
         pu_cnt <= 11'h000;
         fault_code <= dfs_pkg::FC_NONE;
         amp_enable <= 1'b0;
         fault_out <= 1'b0;
      end else begin
         state <= next_state;
         pu_cnt <= next_pu_cnt;
         fault_code <= next_code;
         amp_enable <= next_amp;
         fault_out <= next_fault_out;
      end
   end

   assign pif.mode = pat;
   assign pif.count = fault_code;
   assign pif.tick = tick;
   assign led_green = pif.green;
   assign led_red = pif.red;

   dfs_blink u_blink (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .p(pif.gen)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_amp_off_sd: assert property (shutdown |=> !amp_enable)
      else $error("Amplifier enabled during shutdown");
   a_amp_on_run: assert property (state == dfs_pkg::ST_RUN && !shutdown && loop_ok
      && evt == 7'h00 && fault_code == dfs_pkg::FC_NONE |=> amp_enable)
      else $error("Amplifier not enabled while clear");
   a_sd_polarity: assert property (!sd_active_high && !filt[0] |=> !amp_enable)
      else $error("Active-low shutdown ignored");
   a_fault_out_on: assert property (fault_code != dfs_pkg::FC_NONE |-> fault_out)
      else $error("Fault output low with fault latched");
   a_fault_hold: assert property (fault_code != dfs_pkg::FC_NONE && !clear_req
      |=> fault_out && fault_code == $past(fault_code))
      else $error("Latched fault dropped without clear");
   a_loop_latch: assert property (!loop_ok && evt[4:1] == 4'h0 && fault_code == dfs_pkg::FC_NONE
      |=> fault_code == dfs_pkg::FC_INTERLOCK && !amp_enable)
      else $error("Safety loop open not latched");
   a_fault_clear: assert property (clear_req && evt == 7'h00
      |=> fault_code == dfs_pkg::FC_NONE)
      else $error("Fault not cleared by reset");
   a_probe_leave: assert property (state == dfs_pkg::ST_NOPROBE && motor_probed
      |=> state == dfs_pkg::ST_RUN)
      else $error("Probe did not leave steady red");
   a_powerup_red: assert property (state == dfs_pkg::ST_PWRUP |-> led_red && !led_green)
      else $error("Power-up red not shown");
   c_run_enabled: cover property (state == dfs_pkg::ST_RUN && amp_enable);
   c_interlock: cover property (fault_code == dfs_pkg::FC_INTERLOCK);
   c_regen: cover property (pat == dfs_pkg::PAT_FAST && led_green);
endmodule
`default_nettype wire

// *** tb/dfs_ctrl_model.sv ***
// Purpose: Motion controller model for the shutdown and reset pins
// Assumes: Pins change just after a clk_sys rising edge
// Notes: The testbench calls its tasks
`default_nettype none
module dfs_ctrl_model (
   input wire logic clk_sys,
   input wire logic sd_active_high,
   input wire logic fault_out,
   output logic amplifier_disable_input,
   output logic reset_input
);
   timeunit 1ns;
   timeprecision 100ps;
   logic shut;
   initial begin
      shut = 1'b0;
      reset_input = 1'b0;
   end
   // Pin level follows the configured polarity
   always_comb amplifier_disable_input = sd_active_high ? shut : ~shut;
   task automatic set_shutdown(input logic on);
      @(posedge clk_sys);
      #1 shut = on;
   endtask
   // Clear pulse only when a fault is reported
   task automatic clear_fault(input int hold);
      @(posedge clk_sys);
      #1;
      if (fault_out === 1'b1) begin
         reset_input = 1'b1;
         repeat (hold) @(posedge clk_sys);
         #1 reset_input = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the fault status block
// Assumes: TICK_CYCLES of 2 to keep blink timing short
// Notes: Status word is green, red, fault, amp enable
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TC = 2;
   localparam int T_ON = 250 * TC;
   logic clk_sys, nrst, sd_pin, loop_ok, rst_pin, sd_hi, reset_cmd, probed, regen;
   logic [5:0] ev;
   logic led_green, led_red, fault_out, amp_enable;
   int failures = 0;
   int n_compared = 0;
   logic [3:0] q_stat[$];
   int q_flash[$];
   int cnt = 0;
   int on_len = 0;
   int off_len = 0;
   int e;

   dfs_top #(.TICK_CYCLES(TC)) u_dut (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .amplifier_disable_input(sd_pin),
      .motor_safety_loop(loop_ok),
      .reset_input(rst_pin),
      .sd_active_high(sd_hi),
      .reset_cmd(reset_cmd),
      .motor_probed(probed),
      .regen_dump(regen),
      .fault_stall(ev[0]),
      .fault_undervolt(ev[1]),
      .fault_overvolt(ev[2]),
      .fault_overcurrent(ev[3]),
      .fault_overtemp(ev[4]),
      .fault_nvm_checksum(ev[5]),
      .led_green(led_green),
      .led_red(led_red),
      .fault_out(fault_out),
      .amp_enable(amp_enable)
   );

   dfs_ctrl_model u_ctrl (
      .clk_sys(clk_sys),
      .sd_active_high(sd_hi),
      .fault_out(fault_out),
      .amplifier_disable_input(sd_pin),
      .reset_input(rst_pin)
   );

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic stop_test;
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic expect_stat(input logic [3:0] s);
      q_stat.push_back(s);
      step(1);
   endtask

   task automatic wait_flash;
      int i;
      for (i = 0; i < 20000 && q_flash.size() > 0; i++) step(1);
      if (q_flash.size() > 0) begin
         failures++;
         $display("ERROR flash_count expected %0d seen none", q_flash.pop_front());
      end
   endtask

   // Status compare
   always @(negedge clk_sys) begin
      if (q_stat.size() > 0) begin
         n_compared++;
         if ({led_green, led_red, fault_out, amp_enable} !== q_stat[0]) begin
            failures++;
            $display("ERROR status expected %b seen %b", q_stat[0],
               {led_green, led_red, fault_out, amp_enable});
         end
         void'(q_stat.pop_front());
      end
   end

   // Red flash group counter, result after a long dark spell
   always @(negedge clk_sys) begin
      if (led_red === 1'b1) begin
         if (on_len == 0) cnt++;
         on_len++;
         off_len = 0;
         if (on_len > T_ON + 100) cnt = 0;
      end else begin
         on_len = 0;
         off_len++;
         if (off_len == T_ON + 300 && cnt > 0) begin
            n_compared++;
            e = q_flash.size() > 0 ? q_flash.pop_front() : -1;
            if (cnt != e) begin
               failures++;
               $display("ERROR flash_count expected %0d seen %0d", e, cnt);
            end
            cnt = 0;
         end
      end
   end

   initial begin
      #(80000 * 20);
      failures++;
      stop_test();
   end

   initial begin
      nrst = 1'b0;
      sd_hi = 1'b1;
      loop_ok = 1'b1;
      reset_cmd = 1'b0;
      probed = 1'b0;
      regen = 1'b0;
      ev = '0;
      void'($urandom(84));
      repeat (12) @(posedge clk_sys);
      #1 nrst = 1'b1;
      expect_stat(4'b0100);
      step(500 * TC + 100);
      expect_stat(4'b0110);
      probed = 1'b1;
      step(10);
      expect_stat(4'b1001);
      for (int p = 1; p >= 0; p--) begin
         sd_hi = p[0];
         step(10);
         expect_stat(4'b1001);
         u_ctrl.set_shutdown(1'b1);
         step(20);
         expect_stat(4'b1000);
         step(1000);
         expect_stat(4'b0000);
         u_ctrl.set_shutdown(1'b0);
         step(10);
         expect_stat(4'b1001);
      end
      regen = 1'b1;
      step(20);
      expect_stat(4'b1001);
      step(200);
      expect_stat(4'b0001);
      regen = 1'b0;
      for (int c = 1; c <= 7; c++) begin
         step(10 + $urandom_range(0, 30));
         q_flash.push_back(c);
         if (c == 1) begin
            q_flash.push_back(c);
         end
         if (c == 5) begin
            loop_ok = 1'b0;
            step(10);
            expect_stat(4'b0110);
            loop_ok = 1'b1;
         end else begin
            ev[c < 5 ? c - 1 : c - 2] = 1'b1;
            step(1);
            ev = '0;
            step(3);
            expect_stat(4'b0110);
         end
         wait_flash();
         expect_stat(4'b0010);
         if (c == 7) begin
            nrst = 1'b0;
            step(2);
            nrst = 1'b1;
            expect_stat(4'b0100);
            step(500 * TC + 100);
         end else if (c[0]) begin
            reset_cmd = 1'b1;
            step(1);
            reset_cmd = 1'b0;
            step(3);
         end else begin
            u_ctrl.clear_fault(4 + $urandom_range(0, 15));
            step(8);
         end
         expect_stat(4'b1001);
      end
      stop_test();
   end
endmodule
`default_nettype wire
